// ===== include/pmp_pkg.sv
// constants, register map and carrier types for the pll multiplier / prescaler control
package pmp_pkg;
  localparam logic [15:0] PMP_CSR_ADDR   = 16'h1c80;
  localparam logic [15:0] PMP_MUL_ADDR   = 16'h1c88;
  localparam logic [15:0] PMP_PRE_ADDR   = 16'h1c8a;
  localparam int          PMP_PATH_BIT   = 0;
  localparam int          PMP_CODE_LSB   = 0;
  localparam int          PMP_CODE_W     = 5;
  localparam int          PMP_PRE_EN_BIT = 15;
  localparam logic        PMP_PATH_RST   = 1'b0;
  localparam logic [4:0]  PMP_MUL_RST    = 5'h00;
  localparam logic [4:0]  PMP_RATIO_RST  = 5'h00;
  localparam logic        PMP_PRE_EN_RST = 1'b1;
  localparam logic [4:0]  PMP_MUL_MIN    = 5'h02;
  localparam logic [4:0]  PMP_MUL_MAX    = 5'h0f;
  localparam logic [31:0] PMP_REF_HZ     = 32'h0131_2d00;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } pmp_io_req_t;
endpackage

// ===== hw/pmp_ctrl.sv
// pll path select, multiplier select and input prescaler control with its register file
`timescale 1ns/100ps

// What this block does
// - path bit 0 feeds system clocks from reference
// - path bit 1 feeds system clocks from pll
// - path bit is control bit 0, resets 0
// - codes 2..15 select multiply by code value
// - reserved bits read zero, writes ignored
// - prescaler enable bit 15, resets 1, gates divider
// - prescaler divides by ratio field plus one
// - prescaler divides reference before pll input
// - locked frequency set by multiplier and prescaler
module pmp_ctrl
  import pmp_pkg::*;
#(
  parameter logic [31:0] REF_HZ = PMP_REF_HZ
) (
  input  wire logic        sys_clk_in,              // reference / system clock, 20 MHz
  input  wire logic        rst_n_in,                // async reset, active low
  input  wire pmp_io_req_t io_req_in,               // i/o space access, same clock
  output logic [15:0]      io_rdata_out,            // read data, one cycle after rd
  output logic             path_select_out,         // 0 bypass, 1 pll path
  output logic [4:0]       multiplier_out,          // multiply factor, 0 when code reserved
  output logic             mult_code_bad_out,       // programmed code is reserved
  output logic             prescaler_tick_out,      // one pulse per divided reference period
  output logic [31:0]      pll_freq_hz_out,         // modelled locked pll frequency
  output logic [31:0]      sysclk_src_freq_hz_out   // frequency ahead of the post dividers
);

  if (REF_HZ == 32'h0 || REF_HZ > 32'h1111_1111) begin : g_chk_ref
    $error("REF_HZ must be nonzero and small enough to multiply by 15");
  end

  function automatic logic [4:0] mult_factor(input logic [4:0] code);
    mult_factor = (code >= PMP_MUL_MIN && code <= PMP_MUL_MAX) ? code : 5'h00;
  endfunction

  // reset release through two flops
  logic rst_meta_ff;
  logic rst_sync_ff;
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  wire logic rst_n = rst_sync_ff;

  // register file
  logic        path_sel_ff;
  logic [4:0]  mul_code_ff;
  logic [4:0]  ratio_ff;
  logic        pre_en_ff;
  logic [15:0] rdata_ff;
  logic        nxt_path_sel;
  logic [4:0]  nxt_mul_code;
  logic [4:0]  nxt_ratio;
  logic        nxt_pre_en;
  logic [15:0] nxt_rdata;

  always_comb begin
    nxt_path_sel = path_sel_ff;
    nxt_mul_code = mul_code_ff;
    nxt_ratio    = ratio_ff;
    nxt_pre_en   = pre_en_ff;
    nxt_rdata    = rdata_ff;
    if (io_req_in.wr) begin
      case (io_req_in.addr)
        PMP_CSR_ADDR: begin
          nxt_path_sel = io_req_in.wdata[PMP_PATH_BIT];
        end
        PMP_MUL_ADDR: begin
          // upper bits dropped on write
          nxt_mul_code = io_req_in.wdata[PMP_CODE_LSB +: PMP_CODE_W];
        end
        PMP_PRE_ADDR: begin
          nxt_ratio  = io_req_in.wdata[PMP_CODE_LSB +: PMP_CODE_W];
          nxt_pre_en = io_req_in.wdata[PMP_PRE_EN_BIT];
        end
        default: begin
        end
      endcase
    end
    if (io_req_in.rd) begin
      nxt_rdata = 16'h0000;
      case (io_req_in.addr)
        PMP_CSR_ADDR: nxt_rdata[PMP_PATH_BIT] = path_sel_ff;
        PMP_MUL_ADDR: nxt_rdata[PMP_CODE_LSB +: PMP_CODE_W] = mul_code_ff;
        PMP_PRE_ADDR: begin
          nxt_rdata[PMP_CODE_LSB +: PMP_CODE_W] = ratio_ff;
          nxt_rdata[PMP_PRE_EN_BIT] = pre_en_ff;
        end
        default: nxt_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      path_sel_ff <= PMP_PATH_RST;
      mul_code_ff <= PMP_MUL_RST;
      ratio_ff    <= PMP_RATIO_RST;
      pre_en_ff   <= PMP_PRE_EN_RST;
      rdata_ff    <= 16'h0000;
    end else begin
      path_sel_ff <= nxt_path_sel;
      mul_code_ff <= nxt_mul_code;
      ratio_ff    <= nxt_ratio;
      pre_en_ff   <= nxt_pre_en;
      rdata_ff    <= nxt_rdata;
    end
  end

  // prescaler ahead of the pll: counts reference cycles 0..ratio
  logic [4:0] pre_cnt_ff;
  logic       tick_ff;
  logic [4:0] nxt_pre_cnt;
  logic       nxt_tick;

  always_comb begin
    nxt_pre_cnt = 5'h00;
    nxt_tick    = 1'b0;
    if (pre_en_ff) begin
      // a ratio lowered below the running count wraps at once rather than rolling over 32
      if (pre_cnt_ff >= ratio_ff) begin
        nxt_tick = 1'b1;
      end else begin
        nxt_pre_cnt = pre_cnt_ff + 5'h01;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt_ff <= 5'h00;
      tick_ff    <= 1'b0;
    end else begin
      pre_cnt_ff <= nxt_pre_cnt;
      tick_ff    <= nxt_tick;
    end
  end

  // frequency model; a disabled prescaler starves the pll, so it reads as zero
  logic [4:0]  factor_ff;
  logic        bad_ff;
  logic [31:0] pll_freq_ff;
  logic [31:0] src_freq_ff;
  logic [4:0]  nxt_factor;
  logic        nxt_bad;
  logic [31:0] nxt_pll_freq;
  logic [31:0] nxt_src_freq;

  always_comb begin
    nxt_factor = mult_factor(mul_code_ff);
    nxt_bad    = (nxt_factor == 5'h00);
    nxt_pll_freq = 32'h0;
    if (pre_en_ff && !nxt_bad) begin
      nxt_pll_freq = 32'((REF_HZ / ({27'h0, ratio_ff} + 32'h1))
                         * {27'h0, nxt_factor});
    end
    nxt_src_freq = path_sel_ff ? nxt_pll_freq : REF_HZ;
  end

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      factor_ff   <= 5'h00;
      bad_ff      <= 1'b1;
      pll_freq_ff <= 32'h0;
      src_freq_ff <= REF_HZ;
    end else begin
      factor_ff   <= nxt_factor;
      bad_ff      <= nxt_bad;
      pll_freq_ff <= nxt_pll_freq;
      src_freq_ff <= nxt_src_freq;
    end
  end

  assign io_rdata_out           = rdata_ff;
  assign path_select_out        = path_sel_ff;
  assign multiplier_out         = factor_ff;
  assign mult_code_bad_out      = bad_ff;
  assign prescaler_tick_out     = tick_ff;
  assign pll_freq_hz_out        = pll_freq_ff;
  assign sysclk_src_freq_hz_out = src_freq_ff;

  // checking helpers: spacing between ticks since the ratio last settled
  logic [5:0] gap_ff;
  logic       settled_ff;
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      gap_ff     <= 6'h00;
      settled_ff <= 1'b0;
    end else begin
      gap_ff     <= tick_ff ? 6'h00 : (gap_ff == 6'h3f ? gap_ff : gap_ff + 6'h01);
      settled_ff <= (io_req_in.wr && io_req_in.addr == PMP_PRE_ADDR) ? 1'b0 :
                    (tick_ff ? 1'b1 : settled_ff);
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n);

  sequence s_csr_write;
    io_req_in.wr && io_req_in.addr == PMP_CSR_ADDR;
  endsequence
  sequence s_mul_read;
    io_req_in.rd && io_req_in.addr == PMP_MUL_ADDR;
  endsequence

  chk_bypass_src: assert property (!path_sel_ff |=> sysclk_src_freq_hz_out == REF_HZ)
    else $error("bypass path does not show the reference frequency");
  chk_pll_src: assert property (
      path_sel_ff |=> sysclk_src_freq_hz_out == pll_freq_hz_out)
    else $error("pll path does not show the pll frequency");
  chk_path_write: assert property (
      s_csr_write |=> path_select_out == $past(io_req_in.wdata[PMP_PATH_BIT]))
    else $error("path select did not take the written bit");
  chk_mult_factor: assert property (
      mul_code_ff >= PMP_MUL_MIN && mul_code_ff <= PMP_MUL_MAX
      |=> multiplier_out == $past(mul_code_ff) && !mult_code_bad_out)
    else $error("valid multiplier code not applied");
  chk_bad_code: assert property (
      (mul_code_ff < PMP_MUL_MIN || mul_code_ff > PMP_MUL_MAX)
      |=> mult_code_bad_out && pll_freq_hz_out == 32'h0)
    else $error("reserved multiplier code not flagged");
  chk_reserved_read: assert property (s_mul_read |=> io_rdata_out[15:5] == 11'h000)
    else $error("reserved multiplier bits read nonzero");
  chk_pre_off: assert property (!pre_en_ff ##1 !pre_en_ff |=> !prescaler_tick_out)
    else $error("prescaler ticks while disabled");
  chk_tick_gap: assert property (
      prescaler_tick_out && settled_ff && pre_en_ff
      |-> gap_ff == {1'b0, ratio_ff})
    else $error("prescaler tick spacing differs from ratio plus one");
  chk_freq_model: assert property (
      pre_en_ff && !nxt_bad |=> pll_freq_hz_out ==
      32'((REF_HZ / ({27'h0, $past(ratio_ff)} + 32'h1)) * {27'h0, $past(mul_code_ff)}))
    else $error("pll frequency model mismatch");

endmodule // pmp_ctrl

// ===== verification/pmp_ctrl_bench.sv
// self-checking bench for the pll path, multiplier and prescaler control
`timescale 1ns/100ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module pmp_ctrl_bench;
  import pmp_pkg::*;
  logic        sys_clk_in;
  logic        rst_n_in;
  pmp_io_req_t io_req_in;
  logic [15:0] io_rdata_out;
  logic        path_select_out;
  logic [4:0]  multiplier_out;
  logic        mult_code_bad_out;
  logic        prescaler_tick_out;
  logic [31:0] pll_freq_hz_out;
  logic [31:0] sysclk_src_freq_hz_out;
  int          errors;
  int          cmp_count;

  pmp_ctrl u_dut (
    .sys_clk_in             (sys_clk_in),
    .rst_n_in               (rst_n_in),
    .io_req_in              (io_req_in),
    .io_rdata_out           (io_rdata_out),
    .path_select_out        (path_select_out),
    .multiplier_out         (multiplier_out),
    .mult_code_bad_out      (mult_code_bad_out),
    .prescaler_tick_out     (prescaler_tick_out),
    .pll_freq_hz_out        (pll_freq_hz_out),
    .sysclk_src_freq_hz_out (sysclk_src_freq_hz_out)
  );

  initial begin
    sys_clk_in = 1'b0;
    forever #25 sys_clk_in = ~sys_clk_in;
  end

  task automatic complete_run();
    $display("compares %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // strobe is dropped one cycle later, so back-to-back calls never overlap
  task automatic wr_reg(input logic [15:0] addr, input logic [15:0] data);
    @(negedge sys_clk_in);
    io_req_in = '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(negedge sys_clk_in);
    io_req_in.wr = 1'b0;
  endtask

  task automatic rd_chk(input logic [15:0] addr, input logic [15:0] exp);
    @(negedge sys_clk_in);
    io_req_in = '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 16'h0000};
    @(negedge sys_clk_in);
    io_req_in.rd = 1'b0;
    `CHK(io_rdata_out, exp)
  endtask

  // derived outputs trail the register by one more cycle
  task automatic settle();
    repeat (3) @(negedge sys_clk_in);
  endtask

  // a window of whole periods holds an exact number of pulses
  task automatic count_ticks(input int cycles, input int exp_n);
    int n;
    n = 0;
    repeat (cycles) begin
      @(negedge sys_clk_in);
      if (prescaler_tick_out === 1'b1) n++;
    end
    `CHK(n, exp_n)
  endtask

  initial begin
    logic        ok;
    logic [31:0] pll_exp;
    errors = 0;
    cmp_count = 0;
    rst_n_in = 1'b0;
    io_req_in = '0;
    repeat (6) @(negedge sys_clk_in);
    rst_n_in = 1'b1;
    repeat (4) @(negedge sys_clk_in);
    `CHK(path_select_out, PMP_PATH_RST)
    `CHK(sysclk_src_freq_hz_out, PMP_REF_HZ)
    rd_chk(PMP_CSR_ADDR, 16'h0000);
    rd_chk(PMP_MUL_ADDR, 16'h0000);
    rd_chk(PMP_PRE_ADDR, 16'h8000);
    count_ticks(8, 8);
    $display("test reset values done");
    wr_reg(PMP_MUL_ADDR, 16'hffff);
    rd_chk(PMP_MUL_ADDR, 16'h001f);
    wr_reg(PMP_PRE_ADDR, 16'hffff);
    rd_chk(PMP_PRE_ADDR, 16'h801f);
    wr_reg(16'h1c84, 16'hffff);
    rd_chk(16'h1c84, 16'h0000);
    $display("test reserved bits done");
    wr_reg(PMP_PRE_ADDR, 16'h8003);
    for (int c = 0; c < 32; c++) begin
      ok = (c >= 2 && c <= 15);
      wr_reg(PMP_MUL_ADDR, 16'(c));
      settle();
      pll_exp = ok ? (PMP_REF_HZ / 32'h4) * 32'(c) : 32'h0;
      `CHK(multiplier_out, ok ? 5'(c) : 5'h00)
      `CHK(mult_code_bad_out, ~ok)
      `CHK(pll_freq_hz_out, pll_exp)
      rd_chk(PMP_MUL_ADDR, 16'(c));
    end
    $display("test multiplier codes done");
    wr_reg(PMP_MUL_ADDR, 16'h0006);
    for (int p = 0; p < 2; p++) begin
      wr_reg(PMP_CSR_ADDR, 16'hfffe | 16'(p));
      settle();
      pll_exp = (p == 1) ? (PMP_REF_HZ / 32'h4) * 32'h6 : PMP_REF_HZ;
      `CHK(path_select_out, 1'(p))
      `CHK(sysclk_src_freq_hz_out, pll_exp)
      rd_chk(PMP_CSR_ADDR, 16'(p));
    end
    $display("test path select done");
    for (int k = 0; k < 4; k++) begin
      int r;
      r = (k == 0) ? 0 : (k == 1) ? 1 : (k == 2) ? 4 : 31;
      wr_reg(PMP_PRE_ADDR, 16'h8000 | 16'(r));
      settle();
      pll_exp = (PMP_REF_HZ / 32'(r + 1)) * 32'h6;
      `CHK(pll_freq_hz_out, pll_exp)
      `CHK(sysclk_src_freq_hz_out, pll_exp)
      repeat (r + 2) @(negedge sys_clk_in);
      count_ticks(4 * (r + 1), 4);
    end
    wr_reg(PMP_PRE_ADDR, 16'h0004);
    settle();
    count_ticks(40, 0);
    `CHK(pll_freq_hz_out, 32'h0)
    rd_chk(PMP_PRE_ADDR, 16'h0004);
    $display("test prescaler done");
    // every field was moved off its reset value above, so a second reset must restore them
    rst_n_in = 1'b0;
    repeat (2) @(negedge sys_clk_in);
    rst_n_in = 1'b1;
    repeat (4) @(negedge sys_clk_in);
    rd_chk(PMP_CSR_ADDR, 16'h0000);
    rd_chk(PMP_MUL_ADDR, 16'h0000);
    rd_chk(PMP_PRE_ADDR, 16'h8000);
    `CHK(sysclk_src_freq_hz_out, PMP_REF_HZ)
    count_ticks(8, 8);
    $display("test mid-run reset done");
    complete_run();
  end
endmodule // pmp_ctrl_bench
